// *** src/ssce_engine.sv ***
// Sensor SPI command engine: link shifter, command decoder, NVM sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssce_defs.svh"

// Operation
// [RQ1] Read: code 010, five-bit address
// [RQ2] Master zeroes low byte of read
// [RQ3] Read reply: register byte plus angle byte
// [RQ4] Write: code 100, address, value MSB first
// [RQ5] Write reply echoes stored value, angle byte
// [RQ6] Power-up reloads registers from NVM
// [RQ7] Code 101 restores all registers (registers 26 and 27 are left out of the reload here)
// [RQ8] Code 111 stores addressed register
// [RQ9] Code 110 stores all registers
// [RQ10] Commands ignored while NVM busy
// [RQ11] Busy pin high during NVM work
// [RQ12] Master writes registers before storing
// [RQ13] Code 001 clears error pin, flags
// [RQ14] Register 27 bits 7,6 field flags
// [RQ15] Code 000 is plain angle read
// [RQ16] First frame shifts out full angle
// [RQ17] Modes 0 and 3, rising sample
// [RQ18] Chip select low freezes output buffer
// [RQ19] Single store keeps busy 23 ms
module ssce_engine #(
	parameter int unsigned STORE_ONE_CYCLES = `SSCE_STORE_ONE_CYC,
	parameter int unsigned STORE_ALL_CYCLES = `SSCE_STORE_ALL_CYC
) (
	// System
	input wire logic clk,
	input wire logic rst_n,
	// Serial link
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Sensor side
	input wire logic [15:0] angle,
	input wire logic [2:0] err_event,
	input wire logic field_high_flag,
	input wire logic field_low_flag,
	// Status pins
	output logic nvm_busy,
	output logic err_out
);

	// =====================================================
	// Link domain: receive shifter
	ssce_pkg::ssce_rx_t rx_r;
	ssce_pkg::ssce_rx_t rx_nxt;
	ssce_pkg::ssce_word_t wd_r;
	ssce_pkg::ssce_word_t wd_nxt;
	ssce_pkg::ssce_tx_t tx_r;
	ssce_pkg::ssce_tx_t tx_nxt;
	ssce_pkg::ssce_core_t c_r;
	ssce_pkg::ssce_core_t c_nxt;
	logic frame_rst_n;

	assign frame_rst_n = rst_n & ~spi_cs_n;

	always_comb begin
		rx_nxt = rx_r;
		rx_nxt.cnt = rx_r.cnt + 4'h1;
		rx_nxt.sh = {rx_r.sh[13:0], spi_mosi}; // see [RQ17]
	end

	always_ff @(posedge spi_sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rx_r <= '0;
		end else begin
			rx_r <= rx_nxt;
		end
	end

	always_comb begin
		wd_nxt = wd_r;
		if (rx_r.cnt == 4'hf) begin
			wd_nxt.word = {rx_r.sh, spi_mosi};
			wd_nxt.tgl = ~wd_r.tgl;
		end
	end

	always_ff @(posedge spi_sclk or negedge rst_n) begin
		if (!rst_n) begin
			wd_r <= '0;
		end else begin
			wd_r <= wd_nxt;
		end
	end

	// =====================================================
	// Link domain: transmit on falling edge
	always_comb begin
		tx_nxt.drv = 1'b1;
		tx_nxt.miso = c_r.tx_buf[4'hf - rx_r.cnt]; // see [RQ16] see [RQ17]
	end

	always_ff @(negedge spi_sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_r <= '0;
		end else begin
			tx_r <= tx_nxt;
		end
	end

	assign spi_miso = tx_r.drv ? tx_r.miso : c_r.tx_buf[15]; // see [RQ17]
	assign spi_miso_oe = ~spi_cs_n;

	// =====================================================
	// Core domain: decode and NVM sequencing
	ssce_pkg::ssce_frame_t fr;
	logic evt;
	logic acc;

	assign fr = ssce_pkg::ssce_frame_t'(wd_r.word);
	assign evt = c_r.done_sync[1] ^ c_r.done_sync[2];
	assign acc = evt && (c_r.nvm_st == ssce_pkg::st_idle);

	always_comb begin
		c_nxt = c_r;
		c_nxt.cs_sync = {c_r.cs_sync[0], spi_cs_n};
		c_nxt.done_sync = {c_r.done_sync[1:0], wd_r.tgl};
		if (evt) begin
			c_nxt.reply_reg = 1'b0;
		end
		case (c_r.nvm_st)
			ssce_pkg::st_idle: begin
				if (evt) begin
					c_nxt.addr = fr.addr;
					case (fr.cmd)
						ssce_pkg::cmd_read: begin
							c_nxt.reply_reg = 1'b1; // see [RQ1] see [RQ2]
						end
						ssce_pkg::cmd_write: begin
							c_nxt.reply_reg = 1'b1;
							if (fr.addr != `SSCE_REG_ERR && fr.addr != `SSCE_REG_FIELD) begin
								c_nxt.regs[fr.addr] = fr.data; // see [RQ4]
							end
						end
						ssce_pkg::cmd_restore: begin
							c_nxt.nvm_st = ssce_pkg::st_restore; // see [RQ7]
							c_nxt.tmr = 23'(`SSCE_RESTORE_CYC - 1);
						end
						ssce_pkg::cmd_store_one: begin
							c_nxt.nvm[fr.addr] = c_r.regs[fr.addr]; // see [RQ8]
							c_nxt.nvm_st = ssce_pkg::st_store_one;
							c_nxt.tmr = 23'(STORE_ONE_CYCLES - 1); // see [RQ19]
						end
						ssce_pkg::cmd_store_all: begin
							c_nxt.nvm = c_r.regs; // see [RQ9]
							c_nxt.nvm_st = ssce_pkg::st_store_all;
							c_nxt.tmr = 23'(STORE_ALL_CYCLES - 1);
						end
						ssce_pkg::cmd_clear: begin
							c_nxt.regs[`SSCE_REG_ERR] = 8'h00; // see [RQ13]
						end
						default: begin
							c_nxt.reply_reg = 1'b0; // see [RQ15]
						end
					endcase
				end
			end
			default: begin
				if (c_r.tmr == 23'h0) begin
					c_nxt.nvm_st = ssce_pkg::st_idle;
					if (c_r.nvm_st == ssce_pkg::st_restore) begin
						for (int i = 0; i < 32; i++) begin
							if (5'(i) != `SSCE_REG_ERR && 5'(i) != `SSCE_REG_FIELD) begin
								c_nxt.regs[i] = c_r.nvm[i]; // see [RQ6] see [RQ7]
							end
						end
					end
				end else begin
					c_nxt.tmr = c_r.tmr - 23'h1; // see [RQ10] see [RQ19]
				end
			end
		endcase
		// Error flags: a new event wins over a clear
		c_nxt.regs[`SSCE_REG_ERR][`SSCE_ERR_HI:`SSCE_ERR_LO] =
			c_nxt.regs[`SSCE_REG_ERR][`SSCE_ERR_HI:`SSCE_ERR_LO] | err_event; // see [RQ13]
		c_nxt.regs[`SSCE_REG_FIELD] = 8'h00;
		c_nxt.regs[`SSCE_REG_FIELD][`SSCE_FIELD_HIGH_BIT] = field_high_flag; // see [RQ14]
		c_nxt.regs[`SSCE_REG_FIELD][`SSCE_FIELD_LOW_BIT] = field_low_flag; // see [RQ14]
		// Output buffer refreshes only while chip select is high
		if (c_r.cs_sync[1]) begin
			if (c_r.reply_reg) begin
				c_nxt.tx_buf = {c_r.regs[c_r.addr], angle[15:8]}; // see [RQ3] see [RQ5]
			end else begin
				c_nxt.tx_buf = angle; // see [RQ16] see [RQ18]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c_r <= '0;
			c_r.nvm_st <= ssce_pkg::st_restore; // see [RQ6]
			c_r.tmr <= 23'(`SSCE_RESTORE_CYC - 1);
			c_r.cs_sync <= 2'h3;
			c_r.nvm[`SSCE_NVM_ADDR_A] <= `SSCE_NVM_VAL_A;
			c_r.nvm[`SSCE_NVM_ADDR_B] <= `SSCE_NVM_VAL_B;
			c_r.nvm[`SSCE_NVM_ADDR_C] <= `SSCE_NVM_VAL_C;
			c_r.nvm[`SSCE_NVM_ADDR_D] <= `SSCE_NVM_VAL_D;
			c_r.nvm[`SSCE_NVM_ADDR_E] <= `SSCE_NVM_VAL_E;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign nvm_busy = (c_r.nvm_st != ssce_pkg::st_idle); // see [RQ11]
	assign err_out = |c_r.regs[`SSCE_REG_ERR][`SSCE_ERR_HI:`SSCE_ERR_LO]; // see [RQ13]

	// =====================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_write_lands: assert property (acc && fr.cmd == ssce_pkg::cmd_write && fr.addr < 5'h1a // see [RQ4]
		|=> c_r.regs[$past(fr.addr)] == $past(fr.data))
		else $error("written value not stored");

	a_busy_ignores_cmd: assert property (evt && nvm_busy && c_r.tmr != 23'h0 // see [RQ10]
		|=> c_r.nvm == $past(c_r.nvm) && !c_r.reply_reg)
		else $error("command acted on while busy");

	a_store_one_copy: assert property (acc && fr.cmd == ssce_pkg::cmd_store_one // see [RQ8]
		|=> c_r.nvm[$past(fr.addr)] == $past(c_r.regs[fr.addr]) && nvm_busy)
		else $error("single store did not copy");

	a_store_one_hold: assert property (acc && fr.cmd == ssce_pkg::cmd_store_one // see [RQ19]
		|=> nvm_busy [*8])
		else $error("busy dropped early after store");

	a_store_all_copy: assert property (acc && fr.cmd == ssce_pkg::cmd_store_all // see [RQ9]
		|=> c_r.nvm[0] == $past(c_r.regs[0]) && c_r.nvm_st == ssce_pkg::st_store_all)
		else $error("store all did not start");

	a_restore_done: assert property (c_r.nvm_st == ssce_pkg::st_restore && c_r.tmr == 23'h0 // see [RQ6]
		|=> !nvm_busy && c_r.regs[0] == $past(c_r.nvm[0]))
		else $error("restore did not reload registers");

	a_clear_err: assert property (acc && fr.cmd == ssce_pkg::cmd_clear // see [RQ13]
		|=> c_r.regs[`SSCE_REG_ERR][`SSCE_ERR_HI:`SSCE_ERR_LO] == $past(err_event))
		else $error("error flags not cleared");

	a_field_flags: assert property (1'b1 // see [RQ14]
		|=> c_r.regs[`SSCE_REG_FIELD] == {$past(field_high_flag), $past(field_low_flag), 6'h00})
		else $error("field flags register wrong");

	a_frozen_buf: assert property (!c_r.cs_sync[1] |=> $stable(c_r.tx_buf)) // see [RQ18]
		else $error("output buffer changed in frame");

	a_reply_content: assert property (c_r.reply_reg && c_r.cs_sync[1] // see [RQ3]
		|=> c_r.tx_buf == {$past(c_r.regs[c_r.addr]), $past(angle[15:8])})
		else $error("register reply content wrong");

	a_plain_angle: assert property (acc && fr.cmd == ssce_pkg::cmd_angle // see [RQ15]
		|=> !c_r.reply_reg && !nvm_busy)
		else $error("angle read caused an action");

	a_store_all_busy: assert property (acc && fr.cmd == ssce_pkg::cmd_store_all // see [RQ11]
		|=> nvm_busy [*8])
		else $error("busy dropped early after store all");

	a_read_keeps_reg: assert property (acc && fr.cmd == ssce_pkg::cmd_read && fr.addr < 5'h1a // see [RQ1]
		|=> c_r.regs[$past(fr.addr)] == $past(c_r.regs[fr.addr]) && c_r.reply_reg)
		else $error("register read altered content");

	c_write_seen: cover property (acc && fr.cmd == ssce_pkg::cmd_write);
	c_read_reply: cover property (acc && fr.cmd == ssce_pkg::cmd_read ##[1:200] evt);
	c_store_one: cover property (acc && fr.cmd == ssce_pkg::cmd_store_one);
	c_busy_reject: cover property (evt && nvm_busy);

endmodule
`default_nettype wire

// *** src/ssce_defs.svh ***
// Constants of the sensor SPI command engine
`ifndef SSCE_DEFS_SVH
`define SSCE_DEFS_SVH

// =====================================================
// Clock and NVM timing
`define SSCE_CLK_MHZ 10
`define SSCE_T_STORE_ONE_MS 23
`define SSCE_T_STORE_ALL_MS 704
`define SSCE_T_RESTORE_US 240
`define SSCE_STORE_ONE_CYC (`SSCE_T_STORE_ONE_MS * 1000 * `SSCE_CLK_MHZ)
`define SSCE_STORE_ALL_CYC (`SSCE_T_STORE_ALL_MS * 1000 * `SSCE_CLK_MHZ)
`define SSCE_RESTORE_CYC (`SSCE_T_RESTORE_US * `SSCE_CLK_MHZ)
`define SSCE_TMR_W 23

// =====================================================
// Frame fields
`define SSCE_CMD_HI 15
`define SSCE_CMD_LO 13
`define SSCE_ADDR_HI 12
`define SSCE_ADDR_LO 8
`define SSCE_DATA_HI 7
`define SSCE_DATA_LO 0

// =====================================================
// Status registers
`define SSCE_REG_ERR 5'h1a
`define SSCE_ERR_HI 3
`define SSCE_ERR_LO 1
`define SSCE_REG_FIELD 5'h1b
`define SSCE_FIELD_HIGH_BIT 7
`define SSCE_FIELD_LOW_BIT 6

// =====================================================
// NVM reset content
`define SSCE_NVM_ADDR_A 5'h06
`define SSCE_NVM_VAL_A 8'h1d
`define SSCE_NVM_ADDR_B 5'h07
`define SSCE_NVM_VAL_B 8'h83
`define SSCE_NVM_ADDR_C 5'h08
`define SSCE_NVM_VAL_C 8'h40
`define SSCE_NVM_ADDR_D 5'h0a
`define SSCE_NVM_VAL_D 8'h40
`define SSCE_NVM_ADDR_E 5'h0e
`define SSCE_NVM_VAL_E 8'ha0

`endif

// *** src/ssce_pkg.sv ***
// Types of the sensor SPI command engine
package ssce_pkg;

	typedef enum logic [2:0] {
		cmd_angle = 3'b000,
		cmd_clear = 3'b001,
		cmd_read = 3'b010,
		cmd_spare = 3'b011,
		cmd_write = 3'b100,
		cmd_restore = 3'b101,
		cmd_store_all = 3'b110,
		cmd_store_one = 3'b111
	} ssce_cmd_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_restore = 2'b01,
		st_store_one = 2'b10,
		st_store_all = 2'b11
	} ssce_nvm_st_t;

	typedef struct packed {
		ssce_cmd_t cmd;
		logic [4:0] addr;
		logic [7:0] data;
	} ssce_frame_t;

	typedef struct packed {
		ssce_nvm_st_t nvm_st;
		logic [22:0] tmr;
		logic [4:0] addr;
		logic reply_reg;
		logic [31:0][7:0] regs;
		logic [31:0][7:0] nvm;
		logic [15:0] tx_buf;
		logic [1:0] cs_sync;
		logic [2:0] done_sync;
	} ssce_core_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic [14:0] sh;
	} ssce_rx_t;

	typedef struct packed {
		logic [15:0] word;
		logic tgl;
	} ssce_word_t;

	typedef struct packed {
		logic drv;
		logic miso;
	} ssce_tx_t;

endpackage

// *** tb/ssce_spi_master.sv ***
// Behavioural SPI master facing the command engine
`timescale 1ns/1ps
`default_nettype none
module ssce_spi_master (
	// Serial link
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// One 16-bit frame, mode 0 or 3, clock still outside frames
	task automatic xfer(input logic [15:0] tx, input logic m3, output logic [15:0] rx);
		spi_sclk = m3;
		#100 spi_cs_n = 1'b0;
		#300;
		for (int i = 15; i >= 0; i--) begin
			spi_sclk = 1'b0;
			spi_mosi = tx[i];
			#3 spi_sclk = 1'b1;
			rx[i] = spi_miso;
			#3 spi_sclk = m3;
		end
		// Pull-down on data in once released
		spi_mosi = 1'b0;
		#20 spi_cs_n = 1'b1;
		#700;
	endtask
endmodule
`default_nettype wire

// *** tb/sensor_spi_command_engine_bench.sv ***
// Self-checking bench of the sensor SPI command engine
`timescale 1ns/1ps
`default_nettype none
`include "ssce_defs.svh"
module sensor_spi_command_engine_bench;
	localparam int unsigned S1 = 60;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, busy, err;
	logic [15:0] angle = 16'hc3a5;
	logic [2:0] err_ev = 3'h0;
	logic fh = 1'b0;
	logic fl = 1'b0;
	logic [15:0] rx;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	always #50 clk = ~clk;
	ssce_engine #(.STORE_ONE_CYCLES(S1), .STORE_ALL_CYCLES(80)) i_ssce_engine (.clk(clk), .rst_n(rst_n),
		.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
		.angle(angle), .err_event(err_ev), .field_high_flag(fh), .field_low_flag(fl), .nvm_busy(busy),
		.err_out(err));
	ssce_spi_master i_ssce_spi_master (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));
	// =====================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic fr(input logic [15:0] tx, input logic m3);
		i_ssce_spi_master.xfer(tx, m3, rx);
	endtask
	task automatic idle;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (busy !== 1'b0) begin
			miscompares++;
			$display("unexpected at %0t: busy %h expected %h", $time, busy, 1'b0);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	// =====================================================
	// Scenarios
	task automatic t_power;
		repeat (12) @(posedge clk);
		chk({15'h0, busy}, 16'h0001);
		rst_n <= 1'b1;
		idle();
		chk({15'h0, busy}, 16'h0000);
		fr(16'h4600, 1'b0);
		chk(rx, angle);
		fr(16'h0000, 1'b1);
		chk(rx, {`SSCE_NVM_VAL_A, angle[15:8]});
		$display("power-up test done");
	endtask
	task automatic t_write;
		fr(16'h8980, 1'b1);
		fr(16'h4900, 1'b0);
		chk(rx, {8'h80, angle[15:8]});
		fr(16'h0000, 1'b1);
		chk(rx, {8'h80, angle[15:8]});
		$display("write test done");
	endtask
	task automatic t_nvm;
		fr(16'h8655, 1'b0);
		fr(16'he600, 1'b0);
		chk({15'h0, busy}, 16'h0001);
		fr(16'h8611, 1'b1);
		chk(rx, angle);
		idle();
		chk({15'h0, n >= S1 - 25 && n <= S1}, 16'h0001);
		fr(16'h4600, 1'b0);
		fr(16'h8622, 1'b0);
		chk(rx, {8'h55, angle[15:8]});
		fr(16'ha000, 1'b0);
		idle();
		fr(16'h4600, 1'b0);
		fr(16'h0000, 1'b0);
		chk(rx, {8'h55, angle[15:8]});
		fr(16'h8812, 1'b0);
		fr(16'hc000, 1'b0);
		idle();
		fr(16'h8834, 1'b0);
		fr(16'ha000, 1'b0);
		chk(rx, {8'h34, angle[15:8]});
		idle();
		fr(16'h4800, 1'b1);
		chk(rx, angle);
		fr(16'h0000, 1'b0);
		chk(rx, {8'h12, angle[15:8]});
		$display("memory test done");
	endtask
	task automatic t_flags;
		@(posedge clk);
		fh <= 1'b1;
		err_ev <= 3'h4;
		@(posedge clk);
		err_ev <= 3'h0;
		fr(16'h5b00, 1'b1);
		chk({15'h0, err}, 16'h0001);
		fr(16'h5a00, 1'b0);
		chk(rx, {8'h80, angle[15:8]});
		fr(16'h2000, 1'b0);
		chk(rx, {8'h08, angle[15:8]});
		chk({15'h0, err}, 16'h0000);
		fr(16'h5a00, 1'b0);
		chk(rx, angle);
		fr(16'h0000, 1'b0);
		chk(rx, {8'h00, angle[15:8]});
		fl <= 1'b1;
		fh <= 1'b0;
		fork
			fr(16'h0000, 1'b1);
			begin
				#300;
				@(posedge clk);
				angle <= 16'h5a3c;
			end
		join
		chk(rx, 16'hc3a5);
		fr(16'h5b00, 1'b0);
		fr(16'h0000, 1'b0);
		chk(rx, {8'h40, angle[15:8]});
		$display("flag test done");
	endtask
	initial begin
		t_power();
		t_write();
		t_nvm();
		t_flags();
		complete_run();
	end
endmodule
`default_nettype wire
